// ---- ca_chk.sv ----
`timescale 1ns/10ps

// ==========================================================
// Port checker
module ca_chk (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       cpu_idle,
  input wire logic       irq,
  input wire logic       wdog_reset
);
  logic run_q;
  logic stop_q;
  logic oie_q;
  wire  wm = wr && addr == ca_pkg::ADDR_MODE_CFG;
  wire  wc = wr && addr == ca_pkg::ADDR_CTRL_FLAG;
  wire  rlo = rd && !wr && addr == ca_pkg::ADDR_TB_LOW;
  wire  rc = rd && !wr && addr == ca_pkg::ADDR_CTRL_FLAG;
  wire  h2 = stop_q && cpu_idle;

  // Shadows of control bits, so halts and the overflow interrupt can be judged
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_q <= 1'b0;
      stop_q <= 1'b0;
      oie_q <= 1'b0;
    end
    else
    begin
      if (wc)
        run_q <= wdata[6];
      if (wm)
        stop_q <= wdata[7];
      if (wm)
        oie_q <= wdata[0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  mode_readback_a: assert property (
    wm ##1 !wr ##1 rd && !wr && addr == ca_pkg::ADDR_MODE_CFG
    |=> rdata == $past(wdata, 3)) else $error("mode readback wrong");
  modsel_readback_a: assert property (
    wr && addr == ca_pkg::ADDR_MODSEL0 ##1 !wr ##1 rd && !wr
    && addr == ca_pkg::ADDR_MODSEL0
    |=> rdata == {1'b0, $past(wdata[6:0], 3)}) else $error("modsel bad");
  flag_sticky_a: assert property (
    rc ##1 !wr ##1 rc |=> (rdata & $past(rdata, 2)) == $past(rdata, 2))
    else $error("flag dropped without write");
  tb_halt_a: assert property (
    !run_q && !$past(run_q) && !$past(run_q, 2) && rlo ##1 !run_q && !wr
    ##1 rlo |=> rdata == $past(rdata, 2)) else $error("stopped tb moved");
  idle_halt_a: assert property (
    h2 && $past(h2) && $past(h2, 2) && rlo ##1 h2 && !wr ##1 rlo
    |=> rdata == $past(rdata, 2)) else $error("idle tb moved");
  irq_hold_a: assert property (
    irq && !wr && !$past(wr) |=> irq) else $error("irq dropped");
  wdog_pulse_a: assert property (
    wdog_reset |=> !wdog_reset) else $error("reset pulse too long");
  ovf_irq_a: assert property (
    rc && oie_q ##1 rdata[7] |-> ##[0:2] irq) else $error("no ovf irq");
endmodule : ca_chk

bind ca_top ca_chk u_chk (.ref_clk, .arst_n, .addr, .wdata, .wr, .rd,
  .rdata, .cpu_idle, .irq, .wdog_reset);

// ---- ca_module.sv ----
`timescale 1ns/10ps

// ==========================================================
// One capture/compare module
module ca_module (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic [15:0]         time_base,
  input  wire logic                tick,
  input  wire logic                low_wrap,
  input  wire logic                pin_rise,
  input  wire logic                pin_fall,
  input  wire ca_pkg::module_cfg_t cfg,
  output      ca_pkg::module_stat_t stat
);

  typedef struct packed {
    logic       pin_out;
    logic [7:0] duty;
  } mod_state_t;

  mod_state_t s_q;
  mod_state_t s_d;
  logic       match;
  logic       pwm;
  logic       capture;

  always_comb
  begin
    pwm = cfg.mode[ca_pkg::BIT_PWM_EN] & cfg.mode[ca_pkg::BIT_CMP_EN];
    match = cfg.mode[ca_pkg::BIT_CMP_EN] & tick
          & (time_base == {cfg.cmp_hi, cfg.cmp_lo});
    capture = (cfg.mode[ca_pkg::BIT_FALL_CAP_EN] & pin_fall)
            | (cfg.mode[ca_pkg::BIT_RISE_CAP_EN] & pin_rise);
    s_d = s_q;
    if (pwm)
    begin
      if (low_wrap)
        s_d.duty = cfg.cmp_hi;
      s_d.pin_out = (time_base[7:0] >= s_q.duty);
    end
    else if (match & cfg.mode[ca_pkg::BIT_TOGGLE_EN])
      s_d.pin_out = ~s_q.pin_out;
    stat.pin_out = s_q.pin_out;
    stat.duty = s_q.duty;
    stat.cap_wr = capture;
    stat.event_flag = capture
                    | (match & cfg.mode[ca_pkg::BIT_MATCH_EN] & ~pwm);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule : ca_module

// ---- ca_pkg.sv ----
package ca_pkg;

  // ==========================================================
  // Register map (one byte per register, word index)
  localparam logic [4:0] ADDR_MODE_CFG  = 5'h00;
  localparam logic [4:0] ADDR_CTRL_FLAG = 5'h01;
  localparam logic [4:0] ADDR_TB_LOW    = 5'h02;
  localparam logic [4:0] ADDR_TB_HIGH   = 5'h03;
  localparam logic [4:0] ADDR_MODSEL0   = 5'h04;
  localparam logic [4:0] ADDR_CMPLO0    = 5'h09;
  localparam logic [4:0] ADDR_CMPHI0    = 5'h0E;
  localparam logic [4:0] ADDR_STATUS    = 5'h13;

  // ==========================================================
  // Mode config fields
  localparam int BIT_OVF_IRQ_EN = 0;
  localparam int BIT_SRC_LO     = 1;
  localparam int BIT_SRC_HI     = 2;
  localparam int BIT_WDOG_EN    = 6;
  localparam int BIT_IDLE_STOP  = 7;

  // Control/flag fields
  localparam int BIT_RUN = 6;
  localparam int BIT_OVF = 7;

  // Module mode select fields
  localparam int BIT_MOD_IRQ_EN  = 0;
  localparam int BIT_PWM_EN      = 1;
  localparam int BIT_TOGGLE_EN   = 2;
  localparam int BIT_MATCH_EN    = 3;
  localparam int BIT_FALL_CAP_EN = 4;
  localparam int BIT_RISE_CAP_EN = 5;
  localparam int BIT_CMP_EN      = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Prescale divisors
  localparam int DIV_SLOW_6CLK  = 6;
  localparam int DIV_SLOW_12CLK = 12;
  localparam int DIV_FAST_6CLK  = 2;
  localparam int DIV_FAST_12CLK = 4;

  typedef enum logic [1:0] {
    SRC_OSC_SLOW = 2'b00,
    SRC_OSC_FAST = 2'b01,
    SRC_T0_OVF   = 2'b10,
    SRC_EXT_PIN  = 2'b11
  } count_src_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] cmp_lo;
    logic [7:0] cmp_hi;
  } module_cfg_t;

  typedef struct packed {
    logic       event_flag;
    logic       pin_out;
    logic [7:0] duty;
    logic       cap_wr;
  } module_stat_t;

endpackage : ca_pkg

// ---- ca_top.sv ----
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps

// Behaviour
// - Two-bit source selects osc/6 or /12, osc/2 or /4, timer0, pin.
// - Idle-stop bit halts time base while processor idles.
// - Watchdog-enable bit enables watchdog on module 4 only.
// - Time base counts only while the run bit is set.
// - Time base overflow sets overflow flag; interrupt if enabled.
// - Only software clears the overflow flag.
// - Bits 0..4 are module flags set by hardware, cleared by software.
// - Module bit 0 lets the module flag raise the interrupt.
// - Toggle bit inverts module pin on each compare match.
// - Match bit sets module flag on compare match.
// - Bit 4 arms falling capture, bit 5 rising, both arm either.
// - Bit 6 enables the module comparator.
// - Armed edge copies the 16-bit time base into capture pair.
// - PWM output low while low byte below duty, else high.
// - Duty byte reloads from high compare byte on low byte wrap.
// - Watchdog match on module 4 makes an internal reset pulse.
module ca_top #(
  parameter int NUM_MODULES = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [4:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output      logic [7:0]       rdata,
  input  wire logic             twelve_clk_mode,
  input  wire logic             cpu_idle,
  input  wire logic             timer0_overflow,
  input  wire logic             external_count_input,
  input  wire logic [NUM_MODULES-1:0] module_pin_in,
  output      logic [NUM_MODULES-1:0] module_pin,
  output      logic             irq,
  output      logic             wdog_reset
);

  localparam int N = NUM_MODULES;
  localparam int WDOG_MOD = 4;

  typedef struct packed {
    logic [7:0]   mode_cfg;
    logic [7:0]   ctrl;
    logic [15:0]  tb;
    logic [N-1:0][7:0] modsel;
    logic [N-1:0][7:0] cmp_lo;
    logic [N-1:0][7:0] cmp_hi;
    logic [3:0]   presc;
    logic [1:0]   eci_sync;
    logic         eci_prev;
    logic [N-1:0] pin_s1;
    logic [N-1:0] pin_s2;
    logic [N-1:0] pin_prev;
    logic [N-1:0] pin_out;
    logic         irq;
    logic         wdog;
    logic [7:0]   rdata;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  ca_pkg::module_cfg_t  cfg  [N];
  ca_pkg::module_stat_t stat [N];
  logic                 tick;
  logic                 low_wrap;
  logic [3:0]           div;
  logic                 src_pulse;
  logic [N-1:0]         rise;
  logic [N-1:0]         fall;
  logic [N-1:0]         evt;

  // ==========================================================
  // Module array
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_mod
      assign cfg[g].mode = q.modsel[g];
      assign cfg[g].cmp_lo = q.cmp_lo[g];
      assign cfg[g].cmp_hi = q.cmp_hi[g];
      assign rise[g] = q.pin_s2[g] & ~q.pin_prev[g];
      assign fall[g] = ~q.pin_s2[g] & q.pin_prev[g];
      assign evt[g] = stat[g].event_flag;
      ca_module u_mod (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .time_base (q.tb),
        .tick      (tick),
        .low_wrap  (low_wrap),
        .pin_rise  (rise[g]),
        .pin_fall  (fall[g]),
        .cfg       (cfg[g]),
        .stat      (stat[g])
      );
    end
  endgenerate

  // ==========================================================
  // Time base increment source
  always_comb
  begin
    if (q.mode_cfg[ca_pkg::BIT_SRC_LO])
      div = twelve_clk_mode ? 4'(ca_pkg::DIV_FAST_12CLK)
                            : 4'(ca_pkg::DIV_FAST_6CLK);
    else
      div = twelve_clk_mode ? 4'(ca_pkg::DIV_SLOW_12CLK)
                            : 4'(ca_pkg::DIV_SLOW_6CLK);
    unique case (ca_pkg::count_src_t'({q.mode_cfg[ca_pkg::BIT_SRC_HI],
                                       q.mode_cfg[ca_pkg::BIT_SRC_LO]}))
      ca_pkg::SRC_OSC_SLOW,
      ca_pkg::SRC_OSC_FAST: src_pulse = (q.presc == div - 4'h1);
      ca_pkg::SRC_T0_OVF:   src_pulse = timer0_overflow;
      ca_pkg::SRC_EXT_PIN:  src_pulse = q.eci_sync[1] & ~q.eci_prev;
    endcase
    tick = src_pulse & q.ctrl[ca_pkg::BIT_RUN]
         & ~(cpu_idle & q.mode_cfg[ca_pkg::BIT_IDLE_STOP]);
    low_wrap = tick & (q.tb[7:0] == 8'hFF);
  end

  // ==========================================================
  // State update
  always_comb
  begin
    d = q;
    d.eci_sync = {q.eci_sync[0], external_count_input};
    d.eci_prev = q.eci_sync[1];
    d.pin_s1 = module_pin_in;
    d.pin_s2 = q.pin_s1;
    d.pin_prev = q.pin_s2;
    d.presc = (q.presc >= div - 4'h1) ? 4'h0 : q.presc + 4'h1;

    // Register writes first so hardware sets below win over clears
    if (wr)
    begin
      if (addr == ca_pkg::ADDR_MODE_CFG)
        d.mode_cfg = wdata;
      if (addr == ca_pkg::ADDR_CTRL_FLAG)
        d.ctrl = wdata & 8'hDF;
      if (addr == ca_pkg::ADDR_TB_LOW)
        d.tb[7:0] = wdata;
      if (addr == ca_pkg::ADDR_TB_HIGH)
        d.tb[15:8] = wdata;
      for (int i = 0; i < N; i++)
      begin
        if (addr == ca_pkg::ADDR_MODSEL0 + 5'(i))
          d.modsel[i] = wdata & 8'h7F;
        if (addr == ca_pkg::ADDR_CMPLO0 + 5'(i))
          d.cmp_lo[i] = wdata;
        if (addr == ca_pkg::ADDR_CMPHI0 + 5'(i))
          d.cmp_hi[i] = wdata;
      end
    end

    if (tick)
    begin
      d.tb = q.tb + 16'h0001;
      if (q.tb == 16'hFFFF)
        d.ctrl[ca_pkg::BIT_OVF] = 1'b1;
    end

    for (int i = 0; i < N; i++)
    begin
      if (stat[i].cap_wr)
      begin
        d.cmp_lo[i] = q.tb[7:0];
        d.cmp_hi[i] = q.tb[15:8];
      end
      if (evt[i])
        d.ctrl[i] = 1'b1;
    end

    // Watchdog match on module 4 compare
    d.wdog = q.mode_cfg[ca_pkg::BIT_WDOG_EN]
           & tick & q.modsel[WDOG_MOD][ca_pkg::BIT_CMP_EN]
           & ~q.modsel[WDOG_MOD][ca_pkg::BIT_PWM_EN]
           & (q.tb == {q.cmp_hi[WDOG_MOD], q.cmp_lo[WDOG_MOD]});

    d.irq = (d.ctrl[ca_pkg::BIT_OVF]
             & d.mode_cfg[ca_pkg::BIT_OVF_IRQ_EN]);
    for (int i = 0; i < N; i++)
      d.irq = d.irq | (d.ctrl[i]
                       & d.modsel[i][ca_pkg::BIT_MOD_IRQ_EN]);

    for (int i = 0; i < N; i++)
      d.pin_out[i] = stat[i].pin_out;

    // Read path, data valid the cycle after the strobe
    d.rdata = 8'h00;
    if (rd)
    begin
      if (addr == ca_pkg::ADDR_MODE_CFG)
        d.rdata = q.mode_cfg;
      if (addr == ca_pkg::ADDR_CTRL_FLAG)
        d.rdata = q.ctrl;
      if (addr == ca_pkg::ADDR_TB_LOW)
        d.rdata = q.tb[7:0];
      if (addr == ca_pkg::ADDR_TB_HIGH)
        d.rdata = q.tb[15:8];
      if (addr == ca_pkg::ADDR_STATUS)
        d.rdata = 8'(q.pin_out);
      for (int i = 0; i < N; i++)
      begin
        if (addr == ca_pkg::ADDR_MODSEL0 + 5'(i))
          d.rdata = q.modsel[i];
        if (addr == ca_pkg::ADDR_CMPLO0 + 5'(i))
          d.rdata = q.cmp_lo[i];
        if (addr == ca_pkg::ADDR_CMPHI0 + 5'(i))
          d.rdata = q.cmp_hi[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign rdata      = q.rdata;
  assign module_pin = q.pin_out;
  assign irq        = q.irq;
  assign wdog_reset = q.wdog;

endmodule : ca_top

// ---- pin_source.sv ----
`timescale 1ns/10ps

// ==========================================================
// Far side: capture pins, count pin and timer 0 pulses
module pin_source (
  input  wire logic       ref_clk,
  input  wire logic [4:0] pin_lvl,
  input  wire logic [1:0] lag,
  output      logic [4:0] pin_q = 5'h00,
  output      logic       ext_q = 1'b0,
  output      logic       t0_q = 1'b0
);
  logic [1:0] dly_q = 2'h0;
  logic [1:0] div_q = 2'h0;

  // A slow source follows its request only after lag cycles
  always @(posedge ref_clk)
  begin
    dly_q <= (pin_lvl == pin_q) ? 2'h0 : dly_q + 2'h1;
    if (dly_q >= lag)
      pin_q <= pin_lvl;
    div_q <= div_q + 2'h1;
    t0_q <= &div_q;
    if (&div_q)
      ext_q <= ~ext_q;
  end
endmodule : pin_source

// ---- tb_counter_array_capture_compare.sv ----
`timescale 1ns/10ps

module tb_counter_array_capture_compare;
  localparam logic [4:0] MC = ca_pkg::ADDR_MODE_CFG;
  localparam logic [4:0] CT = ca_pkg::ADDR_CTRL_FLAG;
  localparam logic [4:0] TL = ca_pkg::ADDR_TB_LOW;
  localparam logic [4:0] TH = ca_pkg::ADDR_TB_HIGH;
  localparam logic [4:0] MS = ca_pkg::ADDR_MODSEL0;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic twelve = 1'b0;
  logic cpu_idle = 1'b0;
  logic [4:0] pin_lvl = 5'h00;
  logic [1:0] lag = 2'h0;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic ext, t0, irq, wd;
  logic [7:0] rdata, v, b;
  logic [4:0] mods [3] = '{5'h00, 5'h01, 5'h04};
  logic [7:0] sel [3] = '{8'h4C, 8'h49, 8'h48};
  int n_mismatch = 0;
  int n_checks = 0;
  int n_wd = 0;
  int seed = 32'h6554;

  ca_top u_dut (.ref_clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
    .twelve_clk_mode(twelve), .cpu_idle, .timer0_overflow(t0),
    .external_count_input(ext), .module_pin_in(pin_in),
    .module_pin(pin_out), .irq, .wdog_reset(wd));
  pin_source u_src (.ref_clk, .pin_lvl, .lag, .pin_q(pin_in),
    .ext_q(ext), .t0_q(t0));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wd === 1'b1) n_wd++;

  // Ticks in 48 running cycles; table order matches the source loop
  function automatic int span(input int i);
    int d [6] = '{ca_pkg::DIV_SLOW_6CLK, ca_pkg::DIV_FAST_6CLK, 4, 8,
                  ca_pkg::DIV_SLOW_12CLK, ca_pkg::DIV_FAST_12CLK};
    return 48 / d[i];
  endfunction : span

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    rd_reg(a, v);
    chk(nm, {8'h00, v}, {8'h00, e});
  endtask : rchk

  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : pause

  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #1_000_000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    b = 8'($random(seed));
    wr_reg(MC, b);
    rchk("mode_cfg", MC, b);
    wr_reg(MS, b);
    rchk("modsel", MS, b & 8'h7F);
    wr_reg(5'h1F, b);
    rchk("unmapped", 5'h1F, 8'h00);
    wr_reg(MS, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      twelve <= (i > 3);
      wr_reg(TL, 8'h00);
      wr_reg(TH, 8'h00);
      wr_reg(MC, 8'((i % 4) << 1));
      wr_reg(CT, 8'h40);
      pause(46);
      wr_reg(CT, 8'h00);
      pause(1);
      rd_reg(TL, v);
      chk("rate", {15'h0, v + 2 >= span(i) && v <= span(i) + 2}, 16'h1);
      rd_reg(TL, b);
      chk("halt", {8'h00, b}, {8'h00, v});
    end
    twelve <= 1'b0;
    cpu_idle <= 1'b1;
    wr_reg(TL, 8'h00);
    wr_reg(MC, 8'h82);
    wr_reg(CT, 8'h40);
    pause(20);
    repeat (2) rchk("idle", TL, 8'h00);
    cpu_idle <= 1'b0;
    pause(20);
    rd_reg(TL, v);
    chk("resume", {15'h0, v != 8'h00}, 16'h1);
    wr_reg(CT, 8'h00);
    wr_reg(TL, 8'h5A);
    wr_reg(TH, 8'hC3);
    wr_reg(MS + 5'h2, 8'h10);
    lag <= 2'($random(seed));
    pin_lvl <= 5'h04;
    pause(10);
    rchk("rise_off", CT, 8'h00);
    pin_lvl <= 5'h00;
    pause(10);
    repeat (2) rchk("fall_cap", CT, 8'h04);
    rchk("cap_lo", ca_pkg::ADDR_CMPLO0 + 5'h2, 8'h5A);
    rchk("cap_hi", ca_pkg::ADDR_CMPHI0 + 5'h2, 8'hC3);
    wr_reg(CT, 8'h00);
    wr_reg(MS + 5'h2, 8'h30);
    pin_lvl <= 5'h04;
    pause(10);
    rchk("both_cap", CT, 8'h04);
    wr_reg(TL, 8'hF0);
    wr_reg(TH, 8'h00);
    wr_reg(ca_pkg::ADDR_CMPHI0 + 5'h4, 8'h80);
    wr_reg(MS + 5'h4, 8'h42);
    pause(3);
    chk("pwm_pre", {15'h0, pin_out[4]}, 16'h1);
    wr_reg(MC, 8'h02);
    wr_reg(CT, 8'h40);
    pause(50);
    wr_reg(CT, 8'h00);
    pause(3);
    chk("pwm_low", {15'h0, pin_out[4]}, 16'h0);
    wr_reg(TL, 8'hA0);
    pause(3);
    chk("pwm_high", {15'h0, pin_out[4]}, 16'h1);
    wr_reg(TL, 8'hF8);
    wr_reg(TH, 8'hFF);
    wr_reg(MC, 8'h03);
    wr_reg(CT, 8'h40);
    pause(30);
    repeat (2) rchk("ovf", CT, 8'hC0);
    chk("ovf_irq", {15'h0, irq}, 16'h1);
    wr_reg(CT, 8'h00);
    pause(3);
    chk("irq_clr", {15'h0, irq}, 16'h0);
    // Module 0 pin may be left high by the random mode byte earlier
    b = {7'h00, pin_out[0]};
    wr_reg(TL, 8'h00);
    wr_reg(TH, 8'h00);
    foreach (mods[k])
    begin
      wr_reg(ca_pkg::ADDR_CMPLO0 + mods[k], 8'h04 << k);
      wr_reg(ca_pkg::ADDR_CMPHI0 + mods[k], 8'h00);
      wr_reg(MS + mods[k], sel[k]);
    end
    wr_reg(MC, 8'h42);
    wr_reg(CT, 8'h40);
    pause(60);
    rchk("match", CT, 8'h53);
    chk("m_irq", {15'h0, irq}, 16'h1);
    chk("toggle", {15'h0, pin_out[0]}, {15'h0, ~b[0]});
    chk("wdog", 16'(n_wd), 16'h1);
    wr_reg(CT, 8'h00);
    pause(3);
    chk("m_clr", {15'h0, irq}, 16'h0);
    rchk("status", ca_pkg::ADDR_STATUS, {7'h00, ~b[0]});
    end_of_test();
  end
endmodule : tb_counter_array_capture_compare
